// ==== hdl/afe_params.svh ====
// constants of the imaging front end control bank: addresses, field
// positions, reset values and mode figures; included by the control bank module only
//
// Overview of operation
// [R1] clearing power enable powers down; setting restores
// [R2] registers keep their values through power down
// [R3] serial port keeps working while powered down
// [R4] host: line mode, 6:1 ratio, writes 03/01
// [R5] host: fast mode, 3:1 ratio, 18 MHz
// [R6] host: fast double sampling clears adjust field
// [R7] host: max speed mode, 2:1, writes 41
// [R8] host: slow mode, even ratio 2n, n>=4
// [R9] slow latency is 16.5 plus 2 per step
// [R10] timing independent of double sampling select
// [R11] six bit addresses decode to the registers
// [R12] address then data, msb first, strobe loads
// [R13] read bit set shifts register out msb first
// [R14] write to soft reset restores all defaults
// [R15] colour select picks red, green or blue words
// [R16] broadcast writes load all three colour words
// [R17] host: fixed setup bits written as reset values
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

`define AFE_FRAME_W     14
`define AFE_READ_BIT    4
`define AFE_NREG        12
`define AFE_SYNC_W      5

`define AFE_A_SAMPLING  6'h01
`define AFE_A_OUTPUT    6'h02
`define AFE_A_CLAMP     6'h03
`define AFE_A_SOFT_RST  6'h04
`define AFE_A_COLOUR    6'h06
`define AFE_A_SYNCDET   6'h08
`define AFE_A_OUTDLY    6'h09
`define AFE_A_OFF_R     6'h20
`define AFE_A_OFF_G     6'h21
`define AFE_A_OFF_B     6'h22
`define AFE_A_OFF_ALL   6'h23
`define AFE_A_GAIN_R    6'h28
`define AFE_A_GAIN_G    6'h29
`define AFE_A_GAIN_B    6'h2A
`define AFE_A_GAIN_ALL  6'h2B

`define AFE_IX_S1       4'h0
`define AFE_IX_S2       4'h1
`define AFE_IX_S3       4'h2
`define AFE_IX_S4       4'h3
`define AFE_IX_S5       4'h4
`define AFE_IX_S6       4'h5
`define AFE_IX_OFF_R    4'h6
`define AFE_IX_OFF_G    4'h7
`define AFE_IX_OFF_B    4'h8
`define AFE_IX_GAIN_R   4'h9
`define AFE_IX_GAIN_G   4'hA
`define AFE_IX_GAIN_B   4'hB
`define AFE_IX_NONE     4'hF

`define AFE_RST_S1      8'h03
`define AFE_RST_S2      8'h23
`define AFE_RST_S3      8'h1F
`define AFE_RST_S4      8'h05
`define AFE_RST_S5      8'h00
`define AFE_RST_S6      8'h16
`define AFE_RST_OFF     8'h80
`define AFE_RST_GAIN    8'h00

`define AFE_P_EN        0
`define AFE_P_CDS       1
`define AFE_P_GAIN_STAGE_OFFSET_SELECT     4
`define AFE_P_TWO       6
`define AFE_P_INV       2
`define AFE_P_EXTREF    3
`define AFE_P_RNG       5
`define AFE_P_LAT       6
`define AFE_P_CLV       0
`define AFE_P_RSA       4
`define AFE_P_LCE       3
`define AFE_P_COL       4
`define AFE_P_POL       4
`define AFE_P_VD        1
`define AFE_P_SDE       0
`define AFE_P_ODS       3

`define AFE_COL_GREEN   2'h1
`define AFE_COL_BLUE    2'h2

`define AFE_RATIO_LINE  8'h06
`define AFE_RATIO_FAST  8'h03
`define AFE_RATIO_MAX   8'h02
`define AFE_SLOW_MIN    8'h08
`define AFE_RATIO_SAT   8'hFF
`define AFE_LAT_BASE_H  10'h021
`define AFE_READ_BITS   4'h8

`endif

// ==== hdl/afe_pkg.sv ====
// types of the imaging front end control bank
// assumes afe_params.svh is included by the modules that use it
package afe_pkg;

    typedef enum logic [2:0]
    {
        AFE_MODE_NONE,
        AFE_MODE_LINE,
        AFE_MODE_FAST,
        AFE_MODE_MAX,
        AFE_MODE_SLOW
    } afe_mode_type;

    typedef struct packed
    {
        logic       power_en;
        logic       double_sampling_select;
        logic [1:0] gain_stage_offset_select;
        logic       two_to_one_mode_bit;
        logic       output_polarity_invert;
        logic       external_reference_select;
        logic       clamp_level_range;
        logic [1:0] output_latency_select;
        logic [3:0] clamp_level_code;
        logic [1:0] reset_sample_adjust;
        logic       level_clamp_enable;
        logic [1:0] colour_select;
        logic       sync_edge_polarity;
        logic [2:0] sync_pulse_delay;
        logic       sync_edge_detect_enable;
        logic [1:0] output_delay_select;
        logic [7:0] offset_code;
        logic [7:0] gain_code;
    } afe_cfg_type;

endpackage : afe_pkg

// ==== hdl/afe_sync_stage.sv ====
// two flip-flop synchroniser for the pins of the control bank
// assumes inputs are asynchronous to i_clk_sys
`timescale 1ns/1ps

module afe_sync_stage #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_arst_n,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // the first stage feeds only the second
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : afe_sync_stage

// ==== hdl/afe_ctrl_bank.sv ====
// serially programmed register bank of the imaging front end, with
// power control, colour word selection and mode/latency tracking
// assumes serial port, master clock and pixel sync are async pins
`timescale 1ns/1ps
`include "afe_params.svh"

module afe_ctrl_bank
    import afe_pkg::*;
(
    // clock and reset
    input  wire logic  i_clk_sys,
    input  wire logic  i_arst_n,
    // serial control port
    input  wire logic  i_serial_clock,
    input  wire logic  i_serial_data_in,
    input  wire logic  i_serial_load_strobe,
    output logic       o_serial_data_out,
    output logic       o_serial_out_active,
    // timing pins
    input  wire logic  i_master_clock,
    input  wire logic  i_pixel_sync,
    // configuration and state
    output afe_cfg_type  o_cfg,
    output logic         o_powered_down,
    output afe_mode_type o_mode,
    output logic [7:0]   o_ratio,
    output logic [9:0]   o_latency_half
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge finding

    logic [`AFE_SYNC_W-1:0] pins_s;
    logic [`AFE_SYNC_W-1:0] pins_prev_q;
    logic [`AFE_SYNC_W-1:0] pins_rise;
    logic [`AFE_SYNC_W-1:0] pins_fall;

    afe_sync_stage #(
        .WIDTH    (`AFE_SYNC_W)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_arst_n (i_arst_n),
        .i_async  ({i_pixel_sync, i_master_clock, i_serial_load_strobe,
                    i_serial_data_in, i_serial_clock}),
        .o_sync   (pins_s)
    );

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pins_prev_q <= '0;
        else
            pins_prev_q <= pins_s;
    end

    assign pins_rise = pins_s & ~pins_prev_q;
    assign pins_fall = ~pins_s & pins_prev_q;

    wire sdi_s      = pins_s[1];
    wire sck_rise   = pins_rise[0];
    wire sck_fall   = pins_fall[0];
    wire sen_rise   = pins_rise[2];
    wire mclk_rise  = pins_rise[3];
    wire psync_rise = pins_rise[4];

    ////////////////////////////////////////////////////////////////////
    // serial frame capture

    logic [`AFE_FRAME_W-1:0] shift_q;

    // never gated by power enable, so software can always wake it
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            shift_q <= '0;
        else if (sck_rise)
            shift_q <= {shift_q[`AFE_FRAME_W-2:0], sdi_s}; // [R3] [R12]
    end

    wire [5:0] w_addr  = shift_q[`AFE_FRAME_W-1:8];
    wire [7:0] w_data  = shift_q[7:0];
    wire [5:0] r_addr  = w_addr & ~6'h10;
    wire       wr_en   = sen_rise & ~w_addr[`AFE_READ_BIT]; // [R12]
    wire       rd_en   = sen_rise & w_addr[`AFE_READ_BIT];  // [R13]

    ////////////////////////////////////////////////////////////////////
    // address decode and register storage

    function automatic logic [3:0] reg_index(input logic [5:0] a);
        case (a)
            `AFE_A_SAMPLING: reg_index = `AFE_IX_S1;
            `AFE_A_OUTPUT:   reg_index = `AFE_IX_S2;
            `AFE_A_CLAMP:    reg_index = `AFE_IX_S3;
            `AFE_A_COLOUR:   reg_index = `AFE_IX_S4;
            `AFE_A_SYNCDET:  reg_index = `AFE_IX_S5;
            `AFE_A_OUTDLY:   reg_index = `AFE_IX_S6;
            `AFE_A_OFF_R:    reg_index = `AFE_IX_OFF_R;
            `AFE_A_OFF_G:    reg_index = `AFE_IX_OFF_G;
            `AFE_A_OFF_B:    reg_index = `AFE_IX_OFF_B;
            `AFE_A_GAIN_R:   reg_index = `AFE_IX_GAIN_R;
            `AFE_A_GAIN_G:   reg_index = `AFE_IX_GAIN_G;
            `AFE_A_GAIN_B:   reg_index = `AFE_IX_GAIN_B;
            default:         reg_index = `AFE_IX_NONE;
        endcase
    endfunction : reg_index

    localparam logic [`AFE_NREG-1:0][7:0] DEF =
    {
        `AFE_RST_GAIN, `AFE_RST_GAIN, `AFE_RST_GAIN,
        `AFE_RST_OFF,  `AFE_RST_OFF,  `AFE_RST_OFF,
        `AFE_RST_S6,   `AFE_RST_S5,   `AFE_RST_S4,
        `AFE_RST_S3,   `AFE_RST_S2,   `AFE_RST_S1
    };

    logic [`AFE_NREG-1:0][7:0] regs_q;

    wire [3:0] w_idx    = reg_index(w_addr);                // [R11]
    wire [3:0] r_idx    = reg_index(r_addr);                // [R11]
    wire       soft_rst = wr_en & (w_addr == `AFE_A_SOFT_RST);
    wire       bc_off   = wr_en & (w_addr == `AFE_A_OFF_ALL);
    wire       bc_gain  = wr_en & (w_addr == `AFE_A_GAIN_ALL);

    genvar gi;
    generate
        for (gi = 0; gi < `AFE_NREG; gi++)
        begin : g_reg
            wire is_off  = (gi >= `AFE_IX_OFF_R) && (gi <= `AFE_IX_OFF_B);
            wire is_gain = (gi >= `AFE_IX_GAIN_R) && (gi <= `AFE_IX_GAIN_B);
            wire hit     = (wr_en && (w_idx == 4'(gi)))          // [R11]
                         || (bc_off && is_off)                   // [R16]
                         || (bc_gain && is_gain);                // [R16]

            // power enable plays no part here: contents ride through
            always_ff @(posedge i_clk_sys or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    regs_q[gi] <= DEF[gi];
                else if (soft_rst)
                    regs_q[gi] <= DEF[gi];                       // [R14]
                else if (hit)
                    regs_q[gi] <= w_data;                        // [R2]
            end
        end
    endgenerate

    // write-only and unmapped addresses read back as zero
    wire [7:0] rd_value = (r_idx == `AFE_IX_NONE) ? 8'h00
                                                  : regs_q[r_idx];

    ////////////////////////////////////////////////////////////////////
    // read-back shifter, moved on falling serial clock

    logic [7:0] rd_shift_q;
    logic [3:0] rd_cnt_q;

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rd_shift_q <= 8'h00;
            rd_cnt_q   <= 4'h0;
        end
        else if (rd_en)
        begin
            rd_shift_q <= rd_value;                              // [R13]
            rd_cnt_q   <= `AFE_READ_BITS;
        end
        else if (sck_fall && (rd_cnt_q != 4'h0))
        begin
            rd_shift_q <= {rd_shift_q[6:0], 1'b0};               // [R13]
            rd_cnt_q   <= rd_cnt_q - 4'h1;
        end
    end

    assign o_serial_out_active = (rd_cnt_q != 4'h0);
    assign o_serial_data_out   = rd_shift_q[7];

    ////////////////////////////////////////////////////////////////////
    // configuration fields and colour word selection

    afe_cfg_type cfg_d;
    afe_cfg_type cfg_q;

    wire [1:0] col = regs_q[`AFE_IX_S4][`AFE_P_COL +: 2];
    // the reserved colour code falls back to the red words
    wire [3:0] off_ix = (col == `AFE_COL_GREEN) ? `AFE_IX_OFF_G :
                        (col == `AFE_COL_BLUE)  ? `AFE_IX_OFF_B :
                                                  `AFE_IX_OFF_R; // [R15]
    wire [3:0] gain_ix = (col == `AFE_COL_GREEN) ? `AFE_IX_GAIN_G :
                         (col == `AFE_COL_BLUE)  ? `AFE_IX_GAIN_B :
                                                   `AFE_IX_GAIN_R; // [R15]

    always_comb
    begin
        cfg_d.power_en                  = regs_q[0][`AFE_P_EN];
        cfg_d.double_sampling_select    = regs_q[0][`AFE_P_CDS];
        cfg_d.gain_stage_offset_select  = regs_q[0][`AFE_P_GAIN_STAGE_OFFSET_SELECT +: 2];
        cfg_d.two_to_one_mode_bit       = regs_q[0][`AFE_P_TWO];
        cfg_d.output_polarity_invert    = regs_q[1][`AFE_P_INV];
        cfg_d.external_reference_select = regs_q[1][`AFE_P_EXTREF];
        cfg_d.clamp_level_range         = regs_q[1][`AFE_P_RNG];
        cfg_d.output_latency_select     = regs_q[1][`AFE_P_LAT +: 2];
        cfg_d.clamp_level_code          = regs_q[2][`AFE_P_CLV +: 4];
        cfg_d.reset_sample_adjust       = regs_q[2][`AFE_P_RSA +: 2];
        cfg_d.level_clamp_enable        = regs_q[3][`AFE_P_LCE];
        cfg_d.colour_select             = col;
        cfg_d.sync_edge_polarity        = regs_q[4][`AFE_P_POL];
        cfg_d.sync_pulse_delay          = regs_q[4][`AFE_P_VD +: 3];
        cfg_d.sync_edge_detect_enable   = regs_q[4][`AFE_P_SDE];
        cfg_d.output_delay_select       = regs_q[5][`AFE_P_ODS +: 2];
        cfg_d.offset_code               = regs_q[off_ix];
        cfg_d.gain_code                 = regs_q[gain_ix];
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cfg_q <= '0;
        else
            cfg_q <= cfg_d;
    end

    assign o_cfg          = cfg_q;
    assign o_powered_down = ~cfg_q.power_en;                     // [R1]

    ////////////////////////////////////////////////////////////////////
    // master clock per pixel sync ratio, mode and latency
    // limitation: a master clock faster than half i_clk_sys is not seen

    logic [7:0]   cnt_q;
    logic [7:0]   ratio_q;
    afe_mode_type mode_q;
    afe_mode_type mode_d;
    logic [9:0]   lat_q;
    logic [9:0]   lat_d;

    wire slow = (ratio_q >= `AFE_SLOW_MIN) && !ratio_q[0];

    // double sampling select is deliberately not an input here
    assign mode_d = slow                         ? AFE_MODE_SLOW :
                    (ratio_q == `AFE_RATIO_LINE) ? AFE_MODE_LINE :
                    (ratio_q == `AFE_RATIO_FAST) ? AFE_MODE_FAST :
                    (ratio_q == `AFE_RATIO_MAX)  ? AFE_MODE_MAX  :
                                                   AFE_MODE_NONE; // [R10]

    // latency in half master periods: 33 + 2 * (ratio - 8)
    assign lat_d = slow ? `AFE_LAT_BASE_H
                          + {1'b0, ratio_q - `AFE_SLOW_MIN, 1'b0}
                        : 10'h000;                               // [R9]

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_q   <= 8'h00;
            ratio_q <= 8'h00;
        end
        else if (psync_rise)
        begin
            ratio_q <= cnt_q;
            cnt_q   <= {7'h00, mclk_rise};
        end
        else if (mclk_rise && (cnt_q != `AFE_RATIO_SAT))
            cnt_q   <= cnt_q + 8'h01;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mode_q <= AFE_MODE_NONE;
            lat_q  <= 10'h000;
        end
        else
        begin
            mode_q <= mode_d;
            lat_q  <= lat_d;
        end
    end

    assign o_mode         = mode_q;
    assign o_ratio        = ratio_q;
    assign o_latency_half = lat_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    chk_power_follow: assert property ( // [R1]
        (wr_en && w_addr == `AFE_A_SAMPLING) |=> ##1
        (o_powered_down == !$past(w_data[`AFE_P_EN], 2)))
        else $error("power state does not follow enable write");

    chk_regs_hold: assert property ( // [R2]
        !sen_rise |=> $stable(regs_q))
        else $error("registers changed without a write");

    chk_port_alive: assert property ( // [R3]
        (o_powered_down && sck_rise) |=> (shift_q[0] == $past(sdi_s)))
        else $error("serial port stalled in power down");

    chk_addr_decode: assert property ( // [R11]
        (wr_en && w_addr == `AFE_A_OFF_G) |=>
        (regs_q[`AFE_IX_OFF_G] == $past(w_data))
        && $stable(regs_q[`AFE_IX_OFF_R]))
        else $error("green offset write misdecoded");

    chk_frame_write: assert property ( // [R12]
        (sen_rise && w_addr == `AFE_A_CLAMP) |=> ##1
        (o_cfg.clamp_level_code == $past(w_data[3:0], 2)))
        else $error("strobe did not load the framed word");

    chk_read_shift: assert property ( // [R13]
        rd_en |=> (o_serial_data_out == $past(rd_value[7]))
        ##0 o_serial_out_active)
        else $error("read-back msb not presented");

    chk_soft_reset: assert property ( // [R14]
        soft_rst |=> (regs_q == DEF))
        else $error("soft reset left a register changed");

    chk_colour_pick: assert property ( // [R15]
        (col == `AFE_COL_BLUE) |=>
        (o_cfg.gain_code == $past(regs_q[`AFE_IX_GAIN_B])))
        else $error("blue gain word not selected");

    chk_broadcast: assert property ( // [R16]
        bc_off |=> (regs_q[`AFE_IX_OFF_R] == $past(w_data))
        && (regs_q[`AFE_IX_OFF_G] == $past(w_data))
        && (regs_q[`AFE_IX_OFF_B] == $past(w_data)))
        else $error("broadcast offset not loaded everywhere");

    // mode and latency trail the measured ratio by one cycle
    chk_latency_slow: assert property ( // [R9]
        (o_mode == AFE_MODE_SLOW) |->
        (o_latency_half == 10'(33 + 2 * (int'($past(o_ratio)) - 8))))
        else $error("slow mode latency wrong");

    chk_no_cds_effect: assert property ( // [R10]
        ($changed(cfg_q.double_sampling_select) && $stable(ratio_q))
        |=> $stable(lat_q) && $stable(mode_q))
        else $error("double sampling changed timing");

endmodule : afe_ctrl_bank

// ==== sim/afe_host_model.sv ====
// host controller model: serial control port, master clock, pixel sync
// assumes i_clk_sys paces every pin change; all pins but o_sdi idle low between frames
`timescale 1ns/1ps

module afe_host_model
(
    // clock
    input  wire logic i_clk_sys,
    // pins toward the bank
    output logic      o_sck,
    output logic      o_sdi,
    output logic      o_sen,
    output logic      o_mclk,
    output logic      o_psync,
    // read-back pins
    input  wire logic i_sdo,
    input  wire logic i_act
);
    initial
    begin
        o_sck = 1'b0;
        o_sdi = 1'b1;
        o_sen = 1'b0;
        o_mclk = 1'b0;
        o_psync = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic ticks(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : ticks

    // levels of 4 clocks keep every pin above the 3 clock sampling floor
    task automatic frame(input logic [5:0] a, input logic [7:0] d);
        logic [13:0] w;
        w = {a, d};
        for (int i = 13; i >= 0; i--)
        begin
            o_sdi <= w[i];
            ticks(4);
            o_sck <= 1'b1;
            ticks(4);
            o_sck <= 1'b0;
        end
        // released data line must not keep looking like the last bit
        o_sdi <= ~w[0];
        ticks(4);
        o_sen <= 1'b1;
        ticks(4);
        o_sen <= 1'b0;
        ticks(4);
    endtask : frame

    task automatic read(input logic [5:0] a, output logic [7:0] d,
                        output logic act);
        frame(a | 6'h10, 8'hA5);
        d[7] = i_sdo;
        act = i_act;
        for (int i = 6; i >= -1; i--)
        begin
            o_sck <= 1'b1;
            ticks(4);
            o_sck <= 1'b0;
            ticks(6);
            if (i >= 0)
                d[i] = i_sdo;
        end
    endtask : read

    ////////////////////////////////////////////////////////////////////////
    // sync rises at a master fall, so exactly r master rises lie between
    task automatic pixels(input int r, input int n);
        for (int p = 0; p < n * r; p++)
        begin
            o_mclk <= 1'b1;
            ticks(4);
            o_mclk <= 1'b0;
            o_psync <= (p % r == 0);
            ticks(4);
        end
        o_psync <= 1'b0;
    endtask : pixels
endmodule : afe_host_model

// ==== sim/tb.sv ====
// self-checking bench of the control bank driven through a host model
// assumes afe_pkg compiled first; all pins come from the host model
`timescale 1ns/1ps

module tb
    import afe_pkg::*;
;
    logic         i_clk_sys;
    logic         i_arst_n;
    logic         sck;
    logic         serial_data_in;
    logic         serial_load_strobe;
    logic         serial_data_out;
    logic         sdo_act;
    logic         mclk;
    logic         psync;
    afe_cfg_type  cfg;
    logic         pdn;
    afe_mode_type mode;
    logic [7:0]   ratio;
    logic [9:0]   lat;
    int           mismatches;
    int           checks;

    // write-only, reserved and unmapped places read back as zero
    localparam logic [5:0] DA [17] = '{6'h01, 6'h02, 6'h03, 6'h06,
        6'h08, 6'h09, 6'h20, 6'h21, 6'h22, 6'h28, 6'h29, 6'h2A,
        6'h04, 6'h23, 6'h2B, 6'h0A, 6'h2F};
    localparam logic [7:0] DV [17] = '{8'h03, 8'h23, 8'h1F, 8'h05,
        8'h00, 8'h16, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int MR [6] = '{6, 3, 2, 8, 10, 5};
    localparam logic [7:0] MS [6] = '{8'h03, 8'h03, 8'h41, 8'h03,
        8'h01, 8'h03};
    localparam afe_mode_type MM [6] = '{AFE_MODE_LINE, AFE_MODE_FAST,
        AFE_MODE_MAX, AFE_MODE_SLOW, AFE_MODE_SLOW, AFE_MODE_NONE};

    afe_ctrl_bank uut (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_serial_clock(sck), .i_serial_data_in(serial_data_in),
        .i_serial_load_strobe(serial_load_strobe), .o_serial_data_out(serial_data_out),
        .o_serial_out_active(sdo_act), .i_master_clock(mclk),
        .i_pixel_sync(psync), .o_cfg(cfg), .o_powered_down(pdn),
        .o_mode(mode), .o_ratio(ratio), .o_latency_half(lat));

    afe_host_model host (
        .i_clk_sys(i_clk_sys), .o_sck(sck), .o_sdi(serial_data_in), .o_sen(serial_load_strobe),
        .o_mclk(mclk), .o_psync(psync), .i_sdo(serial_data_out), .i_act(sdo_act));

    initial i_clk_sys = 1'b0;
    always #25 i_clk_sys = ~i_clk_sys;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally(input bit ok, input string what);
        checks++;
        if (!ok)
        begin
            mismatches++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : tally

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, $sformatf("word %h want %h", got, exp));
    endtask : chk_byte

    task automatic chk_lat(input logic [9:0] got, input logic [9:0] exp);
        tally(got === exp, $sformatf("latency %h want %h", got, exp));
    endtask : chk_lat

    task automatic chk_mode(input afe_mode_type got,
                            input afe_mode_type exp);
        tally(got === exp, $sformatf("mode %0d want %0d", got, exp));
    endtask : chk_mode

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       act;
        host.read(a, d, act);
        chk_byte(d, exp);
        chk_byte({7'h00, act}, 8'h01);
        chk_byte({7'h00, sdo_act}, 8'h00);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        chk_byte({7'h00, pdn}, 8'h00);
        chk_byte(cfg.offset_code, 8'h80);
        for (int i = 0; i < 17; i++)
            rd_chk(DA[i], DV[i]);
        $display("defaults done");
    endtask : t_defaults

    task automatic t_colour;
        host.frame(6'h21, 8'h5A);
        host.frame(6'h2A, 8'hC3);
        host.frame(6'h0A, 8'hFF);
        host.frame(6'h06, 8'h15);
        chk_byte(cfg.offset_code, 8'h5A);
        host.frame(6'h06, 8'h25);
        chk_byte(cfg.gain_code, 8'hC3);
        chk_byte(cfg.offset_code, 8'h80);
        host.frame(6'h06, 8'h35);
        chk_byte(cfg.offset_code, 8'h80);
        rd_chk(6'h21, 8'h5A);
        rd_chk(6'h2A, 8'hC3);
        rd_chk(6'h0A, 8'h00);
        $display("colour done");
    endtask : t_colour

    task automatic t_broadcast;
        host.frame(6'h23, 8'h3C);
        host.frame(6'h2B, 8'h7E);
        for (int i = 0; i < 3; i++)
        begin
            rd_chk(6'h20 + 6'(i), 8'h3C);
            rd_chk(6'h28 + 6'(i), 8'h7E);
        end
        $display("broadcast done");
    endtask : t_broadcast

    task automatic t_power;
        host.frame(6'h01, 8'h02);
        chk_byte({7'h00, pdn}, 8'h01);
        chk_byte({7'h00, cfg.power_en}, 8'h00);
        host.frame(6'h22, 8'h11);
        rd_chk(6'h22, 8'h11);
        rd_chk(6'h21, 8'h3C);
        host.frame(6'h01, 8'h03);
        chk_byte({7'h00, pdn}, 8'h00);
        rd_chk(6'h28, 8'h7E);
        $display("power done");
    endtask : t_power

    task automatic t_soft_reset;
        host.frame(6'h04, 8'hA5);
        rd_chk(6'h21, 8'h80);
        rd_chk(6'h28, 8'h00);
        rd_chk(6'h06, 8'h05);
        chk_byte(cfg.offset_code, 8'h80);
        $display("soft reset done");
    endtask : t_soft_reset

    task automatic t_modes;
        logic [9:0] exp_l;
        host.frame(6'h03, 8'h0F);
        for (int i = 0; i < 6; i++)
        begin
            host.frame(6'h01, MS[i]);
            host.pixels(MR[i], 4);
            host.ticks(6);
            // 16.5 periods plus 2 per step of n above four, in halves
            exp_l = 10'h000;
            if (MM[i] == AFE_MODE_SLOW)
                exp_l = 10'(33 + 4 * (MR[i] / 2 - 4));
            chk_byte(ratio, 8'(MR[i]));
            chk_mode(mode, MM[i]);
            chk_lat(lat, exp_l);
        end
        host.frame(6'h01, 8'h03);
        host.pixels(10, 4);
        host.ticks(6);
        chk_mode(mode, AFE_MODE_SLOW);
        chk_lat(lat, 10'h025);
        $display("modes done");
    endtask : t_modes

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // whole run needs about 0.5 ms; four times that means a hang
    initial
    begin
        #2_000_000;
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        i_arst_n = 1'b0;
        mismatches = 0;
        checks = 0;
        repeat (16) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        t_defaults();
        t_colour();
        t_broadcast();
        t_power();
        t_soft_reset();
        t_modes();
        report_and_stop();
    end
endmodule : tb
